// ### fpe_pkg.sv
// Purpose: Constants for the flash program and erase control block
// Assumes: 32-bit register port, 125 MHz clock
// Notes: Byte addresses of the control, staging and status words
package fpe_pkg;
    // ==========================================================
    // Register map
    localparam logic [7:0] FPE_CTRL_OFS = 8'h00;
    localparam logic [7:0] FPE_ADDR_OFS = 8'h04;
    localparam logic [7:0] FPE_DATA0_OFS = 8'h10;
    localparam logic [7:0] FPE_STAT_OFS = 8'h20;
    // ==========================================================
    // Control word fields
    localparam int FPE_OP_LSB = 0;
    localparam int FPE_START_BIT = 4;
    localparam int FPE_UNLOCK_BIT = 14;
    localparam int FPE_BUSY_BIT = 15;
    localparam logic [3:0] FPE_OP_RST = 4'h0;
    // ==========================================================
    // Operation codes
    localparam logic [3:0] FPE_OP_NOP = 4'h0;
    localparam logic [3:0] FPE_OP_WORD = 4'h1;
    localparam logic [3:0] FPE_OP_QUAD = 4'h2;
    localparam logic [3:0] FPE_OP_ROW = 4'h3;
    localparam logic [3:0] FPE_OP_PAGE = 4'h4;
    localparam logic [3:0] FPE_OP_LOWER = 4'h5;
    localparam logic [3:0] FPE_OP_UPPER = 4'h6;
    localparam logic [3:0] FPE_OP_ALL = 4'h7;
    // ==========================================================
    // Geometry in 32-bit words, and bytes per word
    localparam int FPE_ROW_WORDS = 512;
    localparam int FPE_PAGE_WORDS = 4096;
    localparam int FPE_QUAD_WORDS = 4;
    localparam int FPE_WORD_BYTES = 4;
endpackage : fpe_pkg

// ### fpe_addr_gen.sv
// Purpose: Operation span decoder, words and base per operation
// Assumes: Address in bytes, array of ARRAY_WORDS words
// Notes: Base aligned down to the unit of the operation
module fpe_addr_gen
    import fpe_pkg::*;
#(
    parameter int ARRAY_WORDS = 262144
) (
    input wire logic [3:0] op,
    input wire logic [31:0] addr,
    output logic [31:0] base,
    output logic [31:0] count,
    output logic valid
);
    localparam int HALF = ARRAY_WORDS / 2;
    localparam bit SIZE_OK = ARRAY_WORDS > 0
        && ARRAY_WORDS % (2 * FPE_PAGE_WORDS) == 0;
    // Halves must each hold whole pages
    if (!SIZE_OK) begin : g_size_chk
        $error("ARRAY_WORDS must be a multiple of two pages");
    end
    logic [31:0] widx;
    assign widx = addr >> 2;
    always_comb begin
        base = 32'h0;
        count = 32'h0;
        valid = 1'b1;
        unique case (op)
            FPE_OP_WORD: begin
                base = widx;
                count = 32'h1;
            end
            FPE_OP_QUAD: begin
                base = widx & ~32'(FPE_QUAD_WORDS - 1);
                count = 32'(FPE_QUAD_WORDS);
            end
            FPE_OP_ROW: begin // [RULE3]
                base = widx & ~32'(FPE_ROW_WORDS - 1);
                count = 32'(FPE_ROW_WORDS);
            end
            FPE_OP_PAGE: begin // [RULE4]
                base = widx & ~32'(FPE_PAGE_WORDS - 1);
                count = 32'(FPE_PAGE_WORDS);
            end
            FPE_OP_LOWER: begin // [RULE2]
                base = 32'h0;
                count = 32'(HALF);
            end
            FPE_OP_UPPER: begin // [RULE2]
                base = 32'(HALF);
                count = 32'(HALF);
            end
            FPE_OP_ALL: begin // [RULE2]
                base = 32'h0;
                count = 32'(ARRAY_WORDS);
            end
            default: begin // [RULE8]
                valid = 1'b0;
            end
        endcase
    end
endmodule : fpe_addr_gen

// ### fpe_ctrl.sv
// Purpose: Flash program and erase sequencer with register port
// Assumes: Flash accepts one word write or erase per cycle
// Notes: Walks the span of the selected operation one word a cycle
// Summary of operation
// [RULE1] Codes 1,2,3 program word, quad, row
// [RULE2] Codes 4..7 erase page, lower, upper, all
// [RULE3] Row program writes 512 words
// [RULE4] Page erase clears 4096 words
// [RULE5] Operation field writable only when unlocked
// [RULE6] Staging holds four 32-bit words
// [RULE7] Software programs configuration by quad or row
// [RULE8] Codes 8..15 start nothing
module fpe_ctrl
    import fpe_pkg::*;
#(
    parameter int ARRAY_WORDS = 262144
) (
    input wire logic clock,
    input wire logic nrst,
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    output logic flash_we,
    output logic flash_erase,
    output logic [31:0] flash_waddr,
    output logic [31:0] flash_wdata
);
    typedef enum logic [1:0] {
        FPE_IDLE = 2'b01,
        FPE_RUN = 2'b10
    } fpe_state_e;
    typedef struct packed {
        fpe_state_e st;
        logic [3:0] op;
        logic unlock;
        logic [31:0] addr;
        logic [3:0][31:0] data;
        logic [31:0] ptr;
        logic [31:0] left;
        logic [31:0] rdata;
        logic we;
        logic erase;
        logic [31:0] waddr;
        logic [31:0] wdata;
    } fpe_s;
    fpe_s cur_r, cur_nxt;
    logic [31:0] span_base, span_count;
    logic span_valid;
    logic busy;
    logic start;
    logic [3:0] wr_op;
    // ==========================================================
    // Span decoder
    fpe_addr_gen #(.ARRAY_WORDS(ARRAY_WORDS)) u_span (
        .op(cur_r.op),
        .addr(cur_r.addr),
        .base(span_base),
        .count(span_count),
        .valid(span_valid)
    );
    assign busy = (cur_r.st == FPE_RUN);
    assign start = reg_wr && reg_addr == FPE_CTRL_OFS && !busy
        && reg_wdata[FPE_START_BIT];
    assign wr_op = reg_wdata[FPE_OP_LSB +: 4];
    // ==========================================================
    // Next state
    always_comb begin
        cur_nxt = cur_r;
        cur_nxt.we = 1'b0;
        cur_nxt.erase = 1'b0;
        cur_nxt.rdata = 32'h0;
        if (reg_wr && !busy) begin
            unique case (reg_addr)
                FPE_CTRL_OFS: begin
                    if (cur_r.unlock) begin // [RULE5]
                        cur_nxt.op = reg_wdata[FPE_OP_LSB +: 4];
                    end
                    cur_nxt.unlock = reg_wdata[FPE_UNLOCK_BIT];
                end
                FPE_ADDR_OFS: cur_nxt.addr = reg_wdata;
                FPE_DATA0_OFS: cur_nxt.data[0] = reg_wdata; // [RULE6]
                FPE_DATA0_OFS + 8'h04: cur_nxt.data[1] = reg_wdata;
                FPE_DATA0_OFS + 8'h08: cur_nxt.data[2] = reg_wdata;
                FPE_DATA0_OFS + 8'h0c: cur_nxt.data[3] = reg_wdata;
                default: begin
                end
            endcase
        end
        if (reg_rd) begin
            unique case (reg_addr)
                FPE_CTRL_OFS: cur_nxt.rdata = {16'h0, busy, cur_r.unlock,
                    10'h0, cur_r.op};
                FPE_ADDR_OFS: cur_nxt.rdata = cur_r.addr;
                FPE_DATA0_OFS: cur_nxt.rdata = cur_r.data[0];
                FPE_DATA0_OFS + 8'h04: cur_nxt.rdata = cur_r.data[1];
                FPE_DATA0_OFS + 8'h08: cur_nxt.rdata = cur_r.data[2];
                FPE_DATA0_OFS + 8'h0c: cur_nxt.rdata = cur_r.data[3];
                FPE_STAT_OFS: cur_nxt.rdata = cur_r.left;
                default: cur_nxt.rdata = 32'h0;
            endcase
        end
        unique case (cur_r.st)
            FPE_IDLE: begin
                if (start && span_valid) begin // [RULE8]
                    cur_nxt.st = FPE_RUN;
                    cur_nxt.ptr = span_base;
                    cur_nxt.left = span_count;
                end
            end
            FPE_RUN: begin
                // [RULE1] word, quad and row write staged data
                cur_nxt.we = (cur_r.op <= FPE_OP_ROW);
                cur_nxt.erase = (cur_r.op >= FPE_OP_PAGE);
                cur_nxt.waddr = cur_r.ptr << 2;
                cur_nxt.wdata = (cur_r.op <= FPE_OP_ROW)
                    ? cur_r.data[cur_r.ptr[1:0]] : 32'hffffffff;
                cur_nxt.ptr = cur_r.ptr + 32'h1;
                cur_nxt.left = cur_r.left - 32'h1;
                if (cur_r.left == 32'h1) begin
                    cur_nxt.st = FPE_IDLE;
                    cur_nxt.unlock = 1'b0;
                end
            end
        endcase
    end
    // ==========================================================
    // State register
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            cur_r <= '{st: FPE_IDLE, op: FPE_OP_RST, default: '0};
        end else begin
            cur_r <= cur_nxt;
        end
    end
    assign reg_rdata = cur_r.rdata;
    assign flash_we = cur_r.we;
    assign flash_erase = cur_r.erase;
    assign flash_waddr = cur_r.waddr;
    assign flash_wdata = cur_r.wdata;
    // ==========================================================
    // Checks
    default clocking cb @(posedge clock); endclocking
    default disable iff (!nrst);
    op_locked_a: assert property ( // [RULE5]
        !cur_r.unlock |=> $stable(cur_r.op))
        else $error("Operation changed while locked");
    op_written_a: assert property ( // [RULE5]
        reg_wr && !busy && reg_addr == FPE_CTRL_OFS && cur_r.unlock
        |=> cur_r.op == $past(wr_op))
        else $error("Unlocked operation write lost");
    no_reserved_a: assert property ( // [RULE8]
        start && cur_r.op[3] |=> !busy)
        else $error("Reserved code started activity");
    idle_quiet_a: assert property ( // [RULE8]
        !busy && !$past(busy) |-> !flash_we && !flash_erase)
        else $error("Pulse without a running operation");
    row_len_a: assert property ( // [RULE3]
        start && cur_r.op == FPE_OP_ROW |=> cur_r.left == 32'h200)
        else $error("Row length wrong");
    page_len_a: assert property ( // [RULE4]
        start && cur_r.op == FPE_OP_PAGE |=> cur_r.left == 32'h1000)
        else $error("Page length wrong");
    word_one_a: assert property ( // [RULE1]
        start && cur_r.op == FPE_OP_WORD |=> busy ##1 !busy ##0 flash_we)
        else $error("Word program not one cycle");
    quad_four_a: assert property ( // [RULE6]
        start && cur_r.op == FPE_OP_QUAD |=> busy [*4] ##1 !busy)
        else $error("Quad program not four words");
    addr_step_a: assert property ( // [RULE3]
        (flash_we || flash_erase) && busy
        |=> (flash_we || flash_erase)
        && flash_waddr == $past(flash_waddr) + 32'h4)
        else $error("Word address not consecutive");
    erase_kind_a: assert property ( // [RULE2]
        flash_erase |-> !flash_we)
        else $error("Erase and write together");
    erase_fill_a: assert property ( // [RULE2]
        flash_erase |-> flash_wdata == 32'hffffffff)
        else $error("Erased word not blank");
    stage_data_a: assert property ( // [RULE6]
        flash_we |-> flash_wdata == cur_r.data[flash_waddr[3:2]])
        else $error("Written data not from staging");
    unlock_end_a: assert property ( // [RULE5]
        busy && cur_r.left == 32'h1 |=> !busy && !cur_r.unlock)
        else $error("Unlock kept after operation");
    refused_busy_a: assert property (
        busy && reg_wr |=> $stable(cur_r.addr) && $stable(cur_r.data))
        else $error("Register written while busy");
    rdata_idle_a: assert property (
        !$past(reg_rd) |-> reg_rdata == 32'h0)
        else $error("Read data outside its cycle");
    word_c: cover property (start && cur_r.op == FPE_OP_WORD);
    quad_c: cover property (start && cur_r.op == FPE_OP_QUAD);
    row_c: cover property (start && cur_r.op == FPE_OP_ROW);
    erase_c: cover property (start && cur_r.op == FPE_OP_PAGE);
    locked_c: cover property (reg_wr && !cur_r.unlock && !busy);
endmodule : fpe_ctrl

// ### flash_program_erase_control_test.sv
// Purpose: Self-checking bench for the flash program and erase control
// Assumes: Small array of 8192 words keeps erase walks short
// Notes: Bench model predicts pulse counts, base and data per op code
module flash_program_erase_control_test;
    timeunit 1ns;
    timeprecision 1ps;
    import fpe_pkg::*;
    localparam int AW = 8192;
    logic clock = 1'b0;
    logic nrst = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [31:0] reg_rdata, flash_waddr, flash_wdata, d, a, base;
    logic flash_we, flash_erase;
    logic [31:0] stg [4];
    logic [31:0] exp_addr [$];
    logic [31:0] exp_data [$];
    int n_fail = 0;
    int checked = 0;
    int seed = 43;
    int pc_we = 0;
    int pc_er = 0;
    always #4 clock = ~clock;
    fpe_ctrl #(.ARRAY_WORDS(AW)) dut (.clock(clock), .nrst(nrst),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .flash_we(flash_we),
        .flash_erase(flash_erase), .flash_waddr(flash_waddr),
        .flash_wdata(flash_wdata));
    // =========================================================
    // Flash side monitor
    always @(posedge clock) begin
        if (reg_wr === 1'b1 && reg_addr == FPE_CTRL_OFS
            && reg_wdata[FPE_START_BIT] === 1'b1) begin
            pc_we <= 0;
            pc_er <= 0;
        end else if (flash_we === 1'b1 || flash_erase === 1'b1) begin
            pc_we <= pc_we + int'(flash_we === 1'b1);
            pc_er <= pc_er + int'(flash_erase === 1'b1);
            check(32'(exp_addr.size() != 0), 32'h1, "no model");
            if (exp_addr.size() != 0) begin
                check(flash_waddr, exp_addr.pop_front(), "address");
                check(flash_wdata, exp_data.pop_front(), "data");
            end
        end
    end
    // =========================================================
    // Bus tasks and compare
    task automatic wr(input logic [7:0] ad, input logic [31:0] wd);
        @(posedge clock);
        reg_addr <= ad;
        reg_wdata <= wd;
        reg_wr <= 1'b1;
        @(posedge clock);
        reg_wr <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] ad, output logic [31:0] dv);
        @(posedge clock);
        reg_addr <= ad;
        reg_rd <= 1'b1;
        @(posedge clock);
        reg_rd <= 1'b0;
        #1 dv = reg_rdata;
    endtask : rd
    task automatic check(input logic [31:0] seen, input logic [31:0] exp,
                         input string msg);
        checked++;
        if (seen !== exp) begin
            n_fail++;
            $display("unexpected at %0t: %s %h vs %h", $time, msg, seen, exp);
        end
    endtask : check
    task automatic print_verdict;
        $display("checked %0d n_fail %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : print_verdict
    // =========================================================
    // One operation: unlock, select, address, start, wait
    task automatic run_op(input int op);
        int n;
        bit prog;
        a = $random(seed) & 32'h7ffc;
        n = op == 1 ? 1 : op == 2 ? FPE_QUAD_WORDS : op == 3 ? FPE_ROW_WORDS
            : op == 4 ? FPE_PAGE_WORDS : (op == 5 || op == 6) ? AW / 2
            : op == 7 ? AW : 0;
        prog = op >= 1 && op <= 3;
        base = op >= 5 ? (op == 6 ? AW * 2 : 0) : a & ~(n * 4 - 1);
        for (int i = 0; i < n; i++) begin
            exp_addr.push_back(base + 32'(4 * i));
            exp_data.push_back(prog ? stg[((base >> 2) + i) & 3]
                : 32'hffffffff);
        end
        wr(FPE_CTRL_OFS, 32'h4000);
        wr(FPE_CTRL_OFS, 32'h4000 | op);
        rd(FPE_CTRL_OFS, d);
        check(32'(d[3:0]), 32'(op), "op after unlocked write");
        wr(FPE_ADDR_OFS, a);
        wr(FPE_CTRL_OFS, 32'h4010 | op);
        // Write while busy must be ignored
        if (n > 1) wr(FPE_ADDR_OFS, ~a);
        for (int i = 0; i < 20000; i++) begin
            rd(FPE_CTRL_OFS, d);
            if (d[FPE_BUSY_BIT] === 1'b0) break;
        end
        check(32'(d[FPE_BUSY_BIT]), 32'h0, "busy timeout");
        check(32'(pc_we), 32'(prog ? n : 0), "program pulses");
        check(32'(pc_er), 32'(prog ? 0 : n), "erase pulses");
        check(32'(exp_addr.size()), 32'h0, "pulses missing");
        exp_addr.delete();
        exp_data.delete();
        if (n > 0) begin
            check(32'(d[FPE_UNLOCK_BIT]), 32'h0, "unlock after end");
        end
        rd(FPE_ADDR_OFS, d);
        check(d, a, "address kept while busy");
        rd(FPE_STAT_OFS, d);
        check(d, 32'h0, "words left after end");
        $display("op %0d done", op);
    endtask : run_op
    // =========================================================
    // Watchdog
    initial begin
        #400us;
        n_fail++;
        $display("unexpected at %0t: run too long", $time);
        print_verdict;
    end
    // =========================================================
    // Main sequence
    initial begin
        repeat (8) @(posedge clock);
        nrst <= 1'b1;
        rd(FPE_CTRL_OFS, d);
        check(d, 32'h0, "control after reset");
        rd(8'h40, d);
        check(d, 32'h0, "unmapped read");
        wr(FPE_CTRL_OFS, 32'h0003);
        wr(FPE_CTRL_OFS, 32'h4003);
        rd(FPE_CTRL_OFS, d);
        check(32'(d[3:0]), 32'(FPE_OP_RST), "locked op write");
        for (int i = 0; i < 4; i++) begin
            stg[i] = $random(seed);
            wr(FPE_DATA0_OFS + 8'(4 * i), stg[i]);
            rd(FPE_DATA0_OFS + 8'(4 * i), d);
            check(d, stg[i], "staging readback");
        end
        $display("reset and lock tests done");
        for (int op = 0; op < 16; op++) run_op(op);
        $display("all ops done");
        print_verdict;
    end
endmodule : flash_program_erase_control_test
